//--- cdg_pkg.sv
package cdg_pkg;
   // Controller mode expected for this processor interface
   localparam logic [1:0] CDG_MODE_SEL     = 2'h0;
   // Address width for 32 Mbytes of 16-bit words
   localparam int         CDG_ADDR_W       = 24;
   localparam int         CDG_MUX_W        = 12;
   // Row hold and column setup, in clock cycles
   localparam logic [3:0] CDG_ROW_HOLD_CYC = 4'h1;
   localparam logic [3:0] CDG_COL_SET_CYC  = 4'h1;
   // Precharge after an access or refresh
   localparam logic [3:0] CDG_PRECH_CYC    = 4'h2;
   // Refresh request interval and strobe width
   localparam logic [9:0] CDG_RFSH_INTV    = 10'h180;
   localparam logic [3:0] CDG_RFSH_RAS_CYC = 4'h3;
   localparam logic [3:0] CDG_ZERO4        = 4'h0;
   localparam logic [9:0] CDG_ZERO10       = 10'h000;
   // Cycles without a delay-line clock edge before it counts as stopped
   localparam logic [3:0] CDG_DLC_STALL    = 4'hF;
endpackage

//--- cdg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cdg_if;
   import cdg_pkg::*;
   logic                  address_strobe_n;
   logic                  latch_en;
   logic [CDG_ADDR_W-1:0] addr;
   logic                  cs_n;
   logic                  access_strobe_n;
   logic                  xcvr_en_n;
   logic                  access_hold_wait;
   logic [1:0]            mode_sel;

   modport ctrl (
      input  latch_en, addr, cs_n, access_strobe_n, mode_sel,
      output access_hold_wait
   );
   modport cpu (
      output address_strobe_n, latch_en, addr, cs_n, access_strobe_n,
             xcvr_en_n, mode_sel,
      input  access_hold_wait
   );
endinterface
`default_nettype wire

//--- cdg_cpu_end.sv
`timescale 1ns/1ps
`default_nettype none
module cdg_cpu_end
   import cdg_pkg::*;
(
   input  wire logic                  ref_clk_i,
   input  wire logic                  nrst_i,
   cdg_if.cpu                         bus,
   input  wire logic                  req_i,
   input  wire logic [CDG_ADDR_W-1:0] req_addr_i,
   output logic                       busy_o,
   output logic                       done_o
);
   typedef enum logic [2:0]
   {
      CDG_C_IDLE = 3'b001,
      CDG_C_ADS  = 3'b010,
      CDG_C_ACC  = 3'b100
   } cdg_cst_e;

   typedef struct packed
   {
      cdg_cst_e              st;
      logic [CDG_ADDR_W-1:0] lat;
      logic                  done;
   } cdg_cpu_s;

   cdg_cpu_s s_reg;
   cdg_cpu_s s_next;

   always_comb
   begin
      s_next      = s_reg;
      s_next.done = 1'b0;
      unique case (s_reg.st)
         CDG_C_IDLE:
            if (req_i)
            begin
               s_next.st = CDG_C_ADS; // R2
            end
         CDG_C_ADS:
         begin
            s_next.lat = req_addr_i; // R3
            s_next.st  = CDG_C_ACC;
         end
         CDG_C_ACC:
            if (!bus.access_hold_wait)
            begin
               s_next.st   = CDG_C_IDLE;
               s_next.done = 1'b1;
            end
      endcase
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         s_reg.st   <= CDG_C_IDLE;
         s_reg.lat  <= '0;
         s_reg.done <= 1'b0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   logic ads_on;
   assign ads_on = (s_reg.st == CDG_C_ADS);
   assign bus.address_strobe_n = !ads_on; // R2
   // Latch transparent while strobe is low, holds afterwards
   assign bus.addr = ads_on ? req_addr_i : s_reg.lat; // R3
   assign bus.latch_en = !bus.address_strobe_n; // R4
   assign bus.cs_n = (s_reg.st == CDG_C_IDLE);
   assign bus.access_strobe_n = (s_reg.st != CDG_C_ACC);
   assign bus.xcvr_en_n = bus.cs_n | bus.access_strobe_n; // R7
   assign bus.mode_sel = CDG_MODE_SEL; // R1
   assign busy_o = (s_reg.st != CDG_C_IDLE);
   assign done_o = s_reg.done;
endmodule // cdg_cpu_end
`default_nettype wire

//--- cdg_dram_end.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// (R1) System runs the controller in mode 0
// (R2) Processor asserts address strobe with valid address
// (R3) Address latches transparent on strobe, hold after
// (R4) Latch enable is inverse of address strobe
// (R5) Row strobe on first edge after latch enable
// (R6) Row hold, switch to column, setup, column strobe
// (R7) Transceivers enabled by chip select and access strobe
// (R8) Refresh arbitrated; wait output stalls pending access
// (R9) Delay-line clock multiple of 2 MHz; only a stalled clock is flagged, and the testbench drives 25 MHz
// (R10) Up to 32 Mbytes via multiplexed row/column
// (R11) Strobes held until access ends, then precharge
module cdg_dram_end
   import cdg_pkg::*;
#(
   parameter int ADDR_W = CDG_ADDR_W,
   parameter int MUX_W  = CDG_MUX_W
)
(
   input  wire logic             ref_clk_i,
   input  wire logic             nrst_i,
   input  wire logic             delay_line_clock_i,
   cdg_if.ctrl                   bus,
   output logic [MUX_W-1:0]      dram_addr_o,
   output logic                  ras_n_o,
   output logic                  cas_n_o,
   output logic                  mode_err_o
);
   // Access path: IDLE, RAS, COLS, CAS, HOLD, PRE, back to IDLE.
   // Refresh path: IDLE, RFSH, PRE, back to IDLE.
   // HOLD waits on the processor, so a slow access stretches the
   // row strobe; the processor must not stall for longer than the
   // DRAM allows the row strobe to stay low.
   typedef enum logic [6:0]
   {
      CDG_IDLE  = 7'b0000001,
      CDG_RAS   = 7'b0000010,
      CDG_COLS  = 7'b0000100,
      CDG_CAS   = 7'b0001000,
      CDG_PRE   = 7'b0010000,
      CDG_RFSH  = 7'b0100000,
      CDG_HOLD  = 7'b1000000
   } cdg_dst_e;

   typedef struct packed
   {
      cdg_dst_e         st;
      logic [3:0]       cnt;
      logic [9:0]       rcnt;
      logic             rreq;
      logic             pend;
      logic             ras;
      logic             cas;
      logic             colsel;
      logic [MUX_W-1:0] maddr;
      logic             dlc_q;
      logic [3:0]       dlc_idle;
      logic             merr;
   } cdg_dram_s;

   cdg_dram_s s_reg;
   cdg_dram_s s_next;

   // Row half and column half of the latched address
   function automatic logic [MUX_W-1:0] cdg_half
   (
      input logic [ADDR_W-1:0] a,
      input logic              col
   );
      cdg_half = col ? a[MUX_W-1:0] : a[2*MUX_W-1:MUX_W]; // R10
   endfunction

   logic acc_on;
   assign acc_on = bus.latch_en | !bus.access_strobe_n | !bus.cs_n;

   always_comb
   begin
      s_next = s_reg;
      if (s_reg.rcnt == CDG_RFSH_INTV)
      begin
         s_next.rcnt = CDG_ZERO10;
         s_next.rreq = 1'b1;
      end
      else
      begin
         s_next.rcnt = s_reg.rcnt + 10'h001;
      end
      // Only activity of the delay-line clock is watched; its rate
      // cannot be measured against one reference clock cheaply
      s_next.dlc_q = delay_line_clock_i;
      if (delay_line_clock_i != s_reg.dlc_q)
      begin
         s_next.dlc_idle = CDG_ZERO4;
      end
      else if (s_reg.dlc_idle != CDG_DLC_STALL)
      begin
         s_next.dlc_idle = s_reg.dlc_idle + 4'h1;
      end
      s_next.merr = (bus.mode_sel != CDG_MODE_SEL) // R1
                    | (s_reg.dlc_idle == CDG_DLC_STALL); // R9
      if (s_reg.cnt != CDG_ZERO4)
      begin
         s_next.cnt = s_reg.cnt - 4'h1;
      end
      if (bus.latch_en)
      begin
         s_next.pend = 1'b1;
      end
      s_next.maddr = cdg_half(bus.addr, s_reg.colsel);
      unique case (s_reg.st)
         CDG_IDLE:
            if (s_reg.rreq)
            begin
               // Refresh wins a tie so rows never miss their interval
               s_next.st   = CDG_RFSH; // R8
               s_next.ras  = 1'b1;
               s_next.rreq = 1'b0;
               s_next.cnt  = CDG_RFSH_RAS_CYC;
            end
            else if (bus.latch_en || s_reg.pend)
            begin
               s_next.st   = CDG_RAS; // R5
               s_next.ras  = 1'b1;
               s_next.pend = 1'b0;
               s_next.cnt  = CDG_ROW_HOLD_CYC;
            end
         CDG_RAS:
            if (s_reg.cnt == CDG_ZERO4)
            begin
               s_next.colsel = 1'b1; // R6
               s_next.st     = CDG_COLS;
               s_next.cnt    = CDG_COL_SET_CYC;
            end
         CDG_COLS:
            if (s_reg.cnt == CDG_ZERO4)
            begin
               s_next.cas = 1'b1; // R6
               s_next.st  = CDG_CAS;
            end
         CDG_CAS:
            s_next.st = CDG_HOLD;
         CDG_HOLD:
            if (!acc_on)
            begin
               s_next.ras    = 1'b0; // R11
               s_next.cas    = 1'b0;
               s_next.colsel = 1'b0;
               s_next.st     = CDG_PRE;
               s_next.cnt    = CDG_PRECH_CYC;
            end
         CDG_RFSH:
            if (s_reg.cnt == CDG_ZERO4)
            begin
               s_next.ras = 1'b0;
               s_next.st  = CDG_PRE;
               s_next.cnt = CDG_PRECH_CYC;
            end
         CDG_PRE:
            if (s_reg.cnt == CDG_ZERO4)
            begin
               s_next.st = CDG_IDLE; // R11
            end
      endcase
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         s_reg.st     <= CDG_IDLE;
         s_reg.cnt    <= CDG_ZERO4;
         s_reg.rcnt   <= CDG_ZERO10;
         s_reg.rreq   <= 1'b0;
         s_reg.pend   <= 1'b0;
         s_reg.ras    <= 1'b0;
         s_reg.cas    <= 1'b0;
         s_reg.colsel <= 1'b0;
         s_reg.maddr  <= '0;
         s_reg.dlc_q    <= 1'b0;
         s_reg.dlc_idle <= CDG_ZERO4;
         s_reg.merr     <= 1'b0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // Wait holds the processor off until column strobe is reached
   assign bus.access_hold_wait = (bus.latch_en | s_reg.pend
                                 | (s_reg.st == CDG_RAS)
                                 | (s_reg.st == CDG_COLS)
                                 | (s_reg.st == CDG_RFSH)
                                 | (s_reg.st == CDG_PRE)); // R8
   assign dram_addr_o = s_reg.maddr;
   assign ras_n_o     = !s_reg.ras;
   assign cas_n_o     = !s_reg.cas;
   // Registered so a glitch on the select lines cannot pulse the flag
   assign mode_err_o  = s_reg.merr; // R1
endmodule // cdg_dram_end
`default_nettype wire

//--- cdg_props.sv
`timescale 1ns/1ps
`default_nettype none
module cdg_props
   import cdg_pkg::*;
(
   input wire logic       ref_clk_i,
   input wire logic       nrst_i,
   input wire logic       address_strobe_n,
   input wire logic       latch_en,
   input wire logic       cs_n,
   input wire logic       access_strobe_n,
   input wire logic       xcvr_en_n,
   input wire logic       access_hold_wait,
   input wire logic [1:0] mode_sel,
   input wire logic       ras_n_o,
   input wire logic       cas_n_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   a_mode_zero: assert property (mode_sel == CDG_MODE_SEL)
      else $error("mode select not zero");
   a_strobe_pulse: assert property ($fell(address_strobe_n) |=>
      address_strobe_n) else $error("address strobe longer than one cycle");
   a_latch_inverse: assert property (latch_en == !address_strobe_n)
      else $error("latch enable not inverse of address strobe");
   a_ras_after_ale: assert property ($rose(latch_en) |->
      ##[1:16] (!ras_n_o && !cs_n)) else $error("row strobe never came");
   a_cas_after_row: assert property ($fell(cas_n_o) && !cs_n |->
      $past(!ras_n_o, 3)) else $error("column strobe too soon after row");
   a_xcvr_gate: assert property (xcvr_en_n == (cs_n | access_strobe_n))
      else $error("transceiver enable not gated by select and strobe");
   a_wait_release: assert property ($fell(access_hold_wait) && !cs_n |->
      ##[0:1] !cas_n_o) else $error("wait dropped without column strobe");
   a_strobes_held: assert property (!cas_n_o && !cs_n |=> !ras_n_o)
      else $error("row strobe released during access");
   a_precharge: assert property ($rose(ras_n_o) |->
      cas_n_o ##1 ras_n_o [*2]) else $error("precharge cut short");
endmodule // cdg_props
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import cdg_pkg::*;
   logic                  ref_clk_i = 1'b0;
   logic                  nrst_i = 1'b0;
   logic                  dlc = 1'b0;
   logic                  req_i = 1'b0;
   logic [CDG_ADDR_W-1:0] req_addr_i = '0;
   logic                  busy_o;
   logic                  done_o;
   logic [CDG_MUX_W-1:0]  dram_addr_o;
   logic                  ras_n_o;
   logic                  cas_n_o;
   logic                  mode_err_o;
   logic                  prev_cas = 1'b1;
   logic [CDG_MUX_W-1:0]  col_q[$];
   int                    bad_count = 0;
   int                    checks_done = 0;
   cdg_if bus();
   cdg_cpu_end u_cdg_cpu_end(.ref_clk_i, .nrst_i, .bus(bus), .req_i,
      .req_addr_i, .busy_o, .done_o);
   cdg_dram_end u_cdg_dram_end(.ref_clk_i, .nrst_i,
      .delay_line_clock_i(dlc), .bus(bus), .dram_addr_o, .ras_n_o,
      .cas_n_o, .mode_err_o);
   cdg_props u_cdg_props(.ref_clk_i, .nrst_i,
      .address_strobe_n(bus.address_strobe_n), .latch_en(bus.latch_en),
      .cs_n(bus.cs_n), .access_strobe_n(bus.access_strobe_n),
      .xcvr_en_n(bus.xcvr_en_n), .access_hold_wait(bus.access_hold_wait),
      .mode_sel(bus.mode_sel), .ras_n_o, .cas_n_o);
   always #5 ref_clk_i = ~ref_clk_i;
   // 25 MHz, not a multiple of 2 MHz
   always #20 dlc = ~dlc;
   task automatic cmp_bit(input string n, input logic e, input logic g);
      checks_done++;
      if (g !== e)
      begin
         bad_count++;
         $display("unexpected %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic cmp_col(input string n, input logic [CDG_MUX_W-1:0] e,
      input logic [CDG_MUX_W-1:0] g);
      checks_done++;
      if (g !== e)
      begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic final_report;
      if (bad_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic do_access(input logic [CDG_ADDR_W-1:0] a);
      int n;
      @(posedge ref_clk_i);
      req_i <= 1'b1;
      req_addr_i <= a;
      col_q.push_back(a[CDG_MUX_W-1:0]);
      @(posedge ref_clk_i);
      req_i <= 1'b0;
      @(posedge ref_clk_i);
      cmp_bit("busy_o", 1'b1, busy_o);
      // Bound covers a refresh plus its precharge ahead of the access
      for (n = 0; n < 200 && done_o !== 1'b1; n++)
         @(posedge ref_clk_i);
      cmp_bit("done_o", 1'b1, done_o);
      if (done_o !== 1'b1)
         final_report();
   endtask
   // Column must sit on the address lines when the column strobe falls
   always @(posedge ref_clk_i)
   begin
      if (nrst_i && prev_cas === 1'b1 && cas_n_o === 1'b0
          && bus.cs_n === 1'b0)
      begin
         if (col_q.size() == 0)
            cmp_col("column queue", '0, 'X);
         else
            cmp_col("dram_addr_o", col_q.pop_front(), dram_addr_o);
      end
      prev_cas <= cas_n_o;
   end
   initial
   begin
      int i;
      void'($urandom(32'h516D));
      repeat (10) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      @(posedge ref_clk_i);
      cmp_bit("mode_err_o", 1'b0, mode_err_o);
      // Random gaps over several refresh intervals force collisions
      for (i = 0; i < 60; i++)
      begin
         if (i == 30)
         begin
            nrst_i <= 1'b0;
            repeat (3) @(posedge ref_clk_i);
            col_q.delete();
            nrst_i <= 1'b1;
         end
         repeat ($urandom_range(0, 20)) @(posedge ref_clk_i);
         do_access(CDG_ADDR_W'($urandom()));
      end
      cmp_bit("queue empty", 1'b1, col_q.size() == 0);
      final_report();
   end
endmodule // tb_top
`default_nettype wire
